// >>> inc/pfs_pkg.sv
package pfs_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] PIN_FLOPPY_SETUP_IDX  = 8'h03;
    localparam logic [7:0] PAR_SER_EXT_SETUP_IDX = 8'h04;
    localparam logic [7:0] PIN_FLOPPY_SETUP_RST  = 8'h70;
    localparam logic [7:0] PAR_SER_EXT_SETUP_RST = 8'h00;
    // fixed-zero read masks
    localparam logic [7:0] PIN_FLOPPY_SETUP_MASK  = 8'hF7;
    localparam logic [7:0] PAR_SER_EXT_SETUP_MASK = 8'h7F;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int GAME_SEL_BIT      = 0;
    localparam int FLOPPY_MODE_BIT   = 1;
    localparam int SHARED_FN_BIT     = 2;
    localparam int DENS_FORCE_BIT    = 4;
    localparam int PERSONA_LSB       = 5;
    localparam int SHARED_EN_BIT     = 7;
    localparam int PP_MODE_LSB       = 0;
    localparam int PP_SHARE_LSB      = 2;
    localparam int MIDI_LSB          = 4;
    localparam int EPP_REV_BIT       = 6;
    // reserved codes and spp parallel mode code
    localparam logic [1:0] PERSONA_RESERVED  = 2'h2;
    localparam logic [1:0] PP_SHARE_RESERVED = 2'h3;
    localparam logic [1:0] PP_MODE_SPP       = 2'h0;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ      = 100_000_000;
    localparam longint MIDI_REF_HZ = 125_000;
    localparam int     MIDI_DIV    = int'(CLK_HZ / MIDI_REF_HZ);
    localparam int     NUM_UARTS   = 2;
    // ------------------------------------------------------------
    // carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic       cfgState;
        logic [7:0] index;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } pfs_cfg_req_t;
endpackage : pfs_pkg

// >>> core/pfs_midi_clkgen.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_midi_clkgen #(
    parameter int DIV = pfs_pkg::MIDI_DIV
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // tick out
    output logic      tick
);
    localparam int CW = $clog2(DIV);

    logic [CW-1:0] count;

    // ------------------------------------------------------------
    // divide chip clock down to the midi reference
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count == CW'(DIV - 1)) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule : pfs_midi_clkgen
`default_nettype wire

// >>> core/pfs_config_regs.sv
// Overview of operation
// RULE1 - setup register reachable only in config, index 03
// RULE2 - setup register resets to 70
// RULE3 - bit1 selects enhanced floppy mode two
// RULE4 - bit3 reserved, reads zero
// RULE5 - bit4 forces density-one output high
// RULE6 - bits6:5 pick floppy personality, 10 reserved
// RULE7 - bits7 and 2 pick shared pin, tristate at reset
// RULE8 - extended register reachable only at index 04
// RULE9 - extended register resets to 00
// RULE10 - parallel modes apply only when printer bit low
// RULE11 - bits3:2 pick floppy-over-parallel sharing, 11 reserved
// RULE12 - bits5:4 enable midi clock per uart
// RULE13 - midi uses 125 kHz derived reference
// RULE14 - cleared lock blocks access until reset
// RULE15 - printer bit high means printer mode
// RULE16 - floppy tristate overrides density-one control
// RULE17 - bit0 picks power-good input or game select
// RULE18 - bit6 picks epp revision, bit7 reads zero
// RULE19 - reserved bits ignore writes, read fixed
`timescale 1ns/1ps
`default_nettype none
module pfs_config_regs (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // configuration access
    input  wire pfs_pkg::pfs_cfg_req_t cfgReq,
    output logic [7:0]                rdData,
    output logic                      rdValid,
    // state from neighbouring config registers
    input  wire logic                 lockEnable,
    input  wire logic                 printerMode,
    input  wire logic                 floppyTristate,
    // inputs from internal logic
    input  wire logic                 programmedDensity,
    input  wire logic                 gameHit,
    input  wire logic                 addrDecodeHit,
    input  wire logic                 clockRunRequest,
    // decoded settings
    output logic                      floppyEnhanced,
    output logic [1:0]                floppyPersona,
    output logic [1:0]                parallelMode,
    output logic [1:0]                parallelShare,
    output logic                      eppRev17,
    output logic [1:0]                midiTick,
    output logic                      powerGood,
    output logic                      clockRunSeenN,
    // density-one pin
    output logic                      densOut,
    output logic                      densOe,
    // power-good / game select pin
    input  wire logic                 gamePinIn,
    output logic                      gamePinOut,
    output logic                      gamePinOe,
    // address decode / clock run pin
    input  wire logic                 sharedPinIn,
    output logic                      sharedPinOut,
    output logic                      sharedPinOe
);
    logic [7:0] pinSetup;
    logic [7:0] extSetup;
    logic       locked;
    logic       midiRef;
    logic [1:0] gameSync;
    logic [1:0] sharedSync;
    logic       accessOk;
    logic       hitSetup;
    logic       hitExt;
    logic [7:0] next_pinSetup;
    logic [7:0] next_extSetup;

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    assign accessOk = cfgReq.cfgState && !locked; // [RULE14]
    assign hitSetup = accessOk && cfgReq.index == pfs_pkg::PIN_FLOPPY_SETUP_IDX; // [RULE1]
    assign hitExt   = accessOk && cfgReq.index == pfs_pkg::PAR_SER_EXT_SETUP_IDX; // [RULE8]

    always_ff @(posedge mclk) begin
        if (rst) begin
            locked <= 1'b0;
        end else if (!lockEnable) begin
            locked <= 1'b1; // [RULE14]
        end
    end

    // ------------------------------------------------------------
    // write values with reserved bits held
    // ------------------------------------------------------------
    always_comb begin
        next_pinSetup = cfgReq.wdata & pfs_pkg::PIN_FLOPPY_SETUP_MASK; // [RULE4]
        if (cfgReq.wdata[pfs_pkg::PERSONA_LSB +: 2] == pfs_pkg::PERSONA_RESERVED) begin
            next_pinSetup[pfs_pkg::PERSONA_LSB +: 2] = pinSetup[pfs_pkg::PERSONA_LSB +: 2]; // [RULE6] [RULE19]
        end
        next_extSetup = cfgReq.wdata & pfs_pkg::PAR_SER_EXT_SETUP_MASK; // [RULE18]
        if (cfgReq.wdata[pfs_pkg::PP_SHARE_LSB +: 2] == pfs_pkg::PP_SHARE_RESERVED) begin
            next_extSetup[pfs_pkg::PP_SHARE_LSB +: 2] = extSetup[pfs_pkg::PP_SHARE_LSB +: 2]; // [RULE11] [RULE19]
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            pinSetup <= pfs_pkg::PIN_FLOPPY_SETUP_RST; // [RULE2]
        end else if (cfgReq.wr && hitSetup) begin
            pinSetup <= next_pinSetup; // [RULE1]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            extSetup <= pfs_pkg::PAR_SER_EXT_SETUP_RST; // [RULE9]
        end else if (cfgReq.wr && hitExt) begin
            extSetup <= next_extSetup; // [RULE8]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdData  <= 8'h00;
            rdValid <= 1'b0;
        end else begin
            rdValid <= cfgReq.rd && (hitSetup || hitExt);
            if (cfgReq.rd && hitSetup) begin
                rdData <= pinSetup & pfs_pkg::PIN_FLOPPY_SETUP_MASK; // [RULE4]
            end else if (cfgReq.rd && hitExt) begin
                rdData <= extSetup & pfs_pkg::PAR_SER_EXT_SETUP_MASK; // [RULE18]
            end else begin
                rdData <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // decoded settings
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            floppyEnhanced <= 1'b0;
            floppyPersona  <= pfs_pkg::PIN_FLOPPY_SETUP_RST[pfs_pkg::PERSONA_LSB +: 2];
            parallelMode   <= pfs_pkg::PP_MODE_SPP;
            parallelShare  <= 2'h0;
            eppRev17       <= 1'b0;
        end else begin
            floppyEnhanced <= pinSetup[pfs_pkg::FLOPPY_MODE_BIT]; // [RULE3]
            floppyPersona  <= pinSetup[pfs_pkg::PERSONA_LSB +: 2]; // [RULE6]
            parallelMode   <= printerMode ? pfs_pkg::PP_MODE_SPP
                                          : extSetup[pfs_pkg::PP_MODE_LSB +: 2]; // [RULE10] [RULE15]
            parallelShare  <= extSetup[pfs_pkg::PP_SHARE_LSB +: 2]; // [RULE11]
            eppRev17       <= extSetup[pfs_pkg::EPP_REV_BIT]; // [RULE18]
        end
    end

    // ------------------------------------------------------------
    // midi reference
    // ------------------------------------------------------------
    pfs_midi_clkgen #(
        .DIV (pfs_pkg::MIDI_DIV)
    ) u_midi (
        .mclk (mclk),
        .rst  (rst),
        .tick (midiRef) // [RULE13]
    );

    genvar u;
    generate
        for (u = 0; u < pfs_pkg::NUM_UARTS; u++) begin : g_midi
            always_ff @(posedge mclk) begin
                if (rst) begin
                    midiTick[u] <= 1'b0;
                end else begin
                    midiTick[u] <= midiRef && extSetup[pfs_pkg::MIDI_LSB + u]; // [RULE12]
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // density-one pin
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            densOut <= 1'b1;
            densOe  <= 1'b0;
        end else begin
            densOe  <= !floppyTristate; // [RULE16]
            densOut <= pinSetup[pfs_pkg::DENS_FORCE_BIT] || programmedDensity; // [RULE5]
        end
    end

    // ------------------------------------------------------------
    // power-good / game select pin
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            gameSync <= 2'h0;
        end else begin
            gameSync <= {gameSync[0], gamePinIn};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            gamePinOut <= 1'b1;
            gamePinOe  <= 1'b0;
            powerGood  <= 1'b0;
        end else begin
            gamePinOe  <= pinSetup[pfs_pkg::GAME_SEL_BIT]; // [RULE17]
            gamePinOut <= !gameHit;
            powerGood  <= !pinSetup[pfs_pkg::GAME_SEL_BIT] && gameSync[1]; // [RULE17]
        end
    end

    // ------------------------------------------------------------
    // address decode / clock run pin
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            sharedSync <= 2'h3;
        end else begin
            sharedSync <= {sharedSync[0], sharedPinIn};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sharedPinOut  <= 1'b1;
            sharedPinOe   <= 1'b0; // [RULE7]
            clockRunSeenN <= 1'b1;
        end else if (!pinSetup[pfs_pkg::SHARED_EN_BIT]) begin
            sharedPinOut  <= 1'b1;
            sharedPinOe   <= 1'b0; // [RULE7]
            clockRunSeenN <= 1'b1;
        end else if (!pinSetup[pfs_pkg::SHARED_FN_BIT]) begin
            sharedPinOut  <= !addrDecodeHit; // [RULE7]
            sharedPinOe   <= 1'b1;
            clockRunSeenN <= 1'b1;
        end else begin
            sharedPinOut  <= 1'b0;
            sharedPinOe   <= clockRunRequest; // [RULE7]
            clockRunSeenN <= sharedSync[1];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_locked_no_write: assert property (@(posedge mclk) disable iff (rst) // [RULE14]
        locked && cfgReq.wr |=> $stable(pinSetup) && $stable(extSetup))
        else $error("write took effect while locked");
    a_setup_write_idx: assert property (@(posedge mclk) disable iff (rst) // [RULE1]
        $changed(pinSetup) |-> $past(cfgReq.wr && cfgReq.cfgState
            && cfgReq.index == pfs_pkg::PIN_FLOPPY_SETUP_IDX))
        else $error("setup register changed without access");
    a_ext_write_idx: assert property (@(posedge mclk) disable iff (rst) // [RULE8]
        $changed(extSetup) |-> $past(cfgReq.wr && cfgReq.cfgState
            && cfgReq.index == pfs_pkg::PAR_SER_EXT_SETUP_IDX))
        else $error("extended register changed without access");
    a_setup_reset_val: assert property (@(posedge mclk) // [RULE2]
        $past(rst) |-> pinSetup == pfs_pkg::PIN_FLOPPY_SETUP_RST)
        else $error("setup register reset value wrong");
    a_ext_reset_val: assert property (@(posedge mclk) // [RULE9]
        $past(rst) |-> extSetup == pfs_pkg::PAR_SER_EXT_SETUP_RST)
        else $error("extended register reset value wrong");
    a_reserved_read0: assert property (@(posedge mclk) disable iff (rst) // [RULE4]
        rdValid |-> !rdData[3] || $past(cfgReq.index) != pfs_pkg::PIN_FLOPPY_SETUP_IDX)
        else $error("reserved bit read nonzero");
    a_ext_bit7_zero: assert property (@(posedge mclk) disable iff (rst) // [RULE18]
        !rdData[7] || $past(cfgReq.index) != pfs_pkg::PAR_SER_EXT_SETUP_IDX)
        else $error("extended bit7 read nonzero");
    a_persona_legal: assert property (@(posedge mclk) disable iff (rst) // [RULE6]
        pinSetup[pfs_pkg::PERSONA_LSB +: 2] != pfs_pkg::PERSONA_RESERVED)
        else $error("reserved personality stored");
    a_dens_tristate: assert property (@(posedge mclk) disable iff (rst) // [RULE16]
        floppyTristate |=> !densOe)
        else $error("density pin driven while floppy tristated");
    a_dens_forced: assert property (@(posedge mclk) disable iff (rst) // [RULE5]
        pinSetup[pfs_pkg::DENS_FORCE_BIT] |=> densOut)
        else $error("density pin not forced high");
    a_pp_printer: assert property (@(posedge mclk) disable iff (rst) // [RULE15]
        printerMode |=> parallelMode == pfs_pkg::PP_MODE_SPP)
        else $error("extended parallel mode while printer mode");
    a_shared_tristate: assert property (@(posedge mclk) disable iff (rst) // [RULE7]
        !pinSetup[pfs_pkg::SHARED_EN_BIT] |=> !sharedPinOe)
        else $error("shared pin driven while reserved");
    a_game_select: assert property (@(posedge mclk) disable iff (rst) // [RULE17]
        !pinSetup[pfs_pkg::GAME_SEL_BIT] |=> !gamePinOe)
        else $error("game pin driven in power-good mode");
    a_midi_gate: assert property (@(posedge mclk) disable iff (rst) // [RULE12]
        !extSetup[pfs_pkg::MIDI_LSB] |=> !midiTick[0])
        else $error("midi tick while disabled");
endmodule : pfs_config_regs
`default_nettype wire

// >>> tb/pfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_host_model (
    // clock
    input  wire logic                 mclk,
    // configuration access
    output var pfs_pkg::pfs_cfg_req_t cfgReq,
    input  wire logic [7:0]           rdData,
    input  wire logic                 rdValid
);
    initial begin
        cfgReq = '0;
    end
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic step;
        @(posedge mclk);
        #1;
    endtask : step
    task automatic set_cfg(input logic on);
        step();
        cfgReq.cfgState = on;
    endtask : set_cfg
    task automatic cfg_write(input logic [7:0] idx, input logic [7:0] data);
        step();
        cfgReq.index = idx;
        cfgReq.wdata = data;
        cfgReq.wr    = 1'b1;
        step();
        cfgReq.wr    = 1'b0;
        // released data bus does not keep its last value
        cfgReq.wdata = ~data;
    endtask : cfg_write
    task automatic cfg_read(input logic [7:0] idx, output logic [7:0] data, output logic ok);
        step();
        cfgReq.index = idx;
        cfgReq.rd    = 1'b1;
        step();
        cfgReq.rd    = 1'b0;
        data         = rdData;
        ok           = rdValid;
    endtask : cfg_read
endmodule : pfs_host_model
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                  mclk, rst, lockEnable, printerMode, floppyTristate, programmedDensity;
    logic                  gameHit, addrDecodeHit, clockRunRequest, pgoodLine;
    logic                  rdValid, floppyEnhanced, eppRev17, powerGood, clockRunSeenN, densOut, densOe;
    logic                  gamePinOut, gamePinOe, sharedPinOut, sharedPinOe;
    logic [7:0]            rdData;
    logic [1:0]            floppyPersona, parallelMode, parallelShare, midiTick;
    pfs_pkg::pfs_cfg_req_t cfgReq;
    int                    n_errors, checks, n0, n1, t0, gap;
    // ------------------------------------------------------------
    // clock and pin wires
    // ------------------------------------------------------------
    always #5 mclk = ~mclk;
    wire gamePinIn   = gamePinOe ? gamePinOut : pgoodLine;
    wire sharedPinIn = sharedPinOe ? sharedPinOut : 1'b1;
    pfs_host_model host_u (.mclk(mclk), .cfgReq(cfgReq), .rdData(rdData), .rdValid(rdValid));
    pfs_config_regs dut_u (
        .mclk(mclk), .rst(rst), .cfgReq(cfgReq), .rdData(rdData), .rdValid(rdValid),
        .lockEnable(lockEnable), .printerMode(printerMode), .floppyTristate(floppyTristate),
        .programmedDensity(programmedDensity), .gameHit(gameHit), .addrDecodeHit(addrDecodeHit),
        .clockRunRequest(clockRunRequest), .floppyEnhanced(floppyEnhanced), .floppyPersona(floppyPersona),
        .parallelMode(parallelMode), .parallelShare(parallelShare), .eppRev17(eppRev17),
        .midiTick(midiTick), .powerGood(powerGood), .clockRunSeenN(clockRunSeenN), .densOut(densOut),
        .densOe(densOe), .gamePinIn(gamePinIn), .gamePinOut(gamePinOut), .gamePinOe(gamePinOe),
        .sharedPinIn(sharedPinIn), .sharedPinOut(sharedPinOut), .sharedPinOe(sharedPinOe));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] idx, input logic expOk, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host_u.cfg_read(idx, d, ok);
        chk({7'h00, ok}, {7'h00, expOk});
        chk(d, exp);
    endtask : rd_chk
    task automatic settle;
        repeat (6) @(posedge mclk);
        #1;
    endtask : settle
    task automatic put(input logic [7:0] idx, input logic [7:0] data);
        host_u.cfg_write(idx, data);
        settle();
    endtask : put
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0; rst = 1'b1; lockEnable = 1'b1; printerMode = 1'b1; floppyTristate = 1'b0;
        programmedDensity = 1'b0; gameHit = 1'b0; addrDecodeHit = 1'b0; clockRunRequest = 1'b0;
        pgoodLine = 1'b1; n_errors = 0; checks = 0;
        repeat (20) @(posedge mclk);
        #1;
        rst = 1'b0;
        host_u.set_cfg(1'b1);
        settle();
        rd_chk(8'h03, 1'b1, 8'h70);
        rd_chk(8'h04, 1'b1, 8'h00);
        chk({5'h00, floppyEnhanced, floppyPersona}, 8'h03);
        chk({7'h00, sharedPinOe}, 8'h00);
        chk({7'h00, densOut}, 8'h01);
        chk({7'h00, powerGood}, 8'h01);
        pgoodLine = 1'b0;
        settle();
        chk({7'h00, powerGood}, 8'h00);
        pgoodLine = 1'b1;
        $display("test reset values done");
        put(8'h03, 8'hFF);
        rd_chk(8'h03, 1'b1, 8'hF7);
        chk({7'h00, floppyEnhanced}, 8'h01);
        chk({5'h00, powerGood, gamePinOe, gamePinOut}, 8'h03);
        chk({7'h00, sharedPinOe}, 8'h00);
        clockRunRequest = 1'b1;
        gameHit         = 1'b1;
        settle();
        chk({5'h00, sharedPinOe, sharedPinOut, clockRunSeenN}, 8'h04);
        chk({7'h00, gamePinOut}, 8'h00);
        gameHit         = 1'b0;
        put(8'h03, 8'h40);
        rd_chk(8'h03, 1'b1, 8'h60);
        programmedDensity = 1'b1;
        settle();
        chk({6'h00, densOe, densOut}, 8'h03);
        programmedDensity = 1'b0;
        floppyTristate = 1'b1;
        settle();
        chk({6'h00, densOe, densOut}, 8'h00);
        for (int p = 3; p >= 0; p--) begin
            put(8'h03, 8'(p << 5) | 8'h80);
            chk({6'h00, floppyPersona}, (p == 2) ? 8'h03 : 8'(p));
        end
        addrDecodeHit = 1'b1;
        settle();
        chk({6'h00, sharedPinOe, sharedPinOut}, 8'h02);
        $display("test pin and floppy setup done");
        put(8'h04, 8'hFF);
        rd_chk(8'h04, 1'b1, 8'h73);
        chk({7'h00, eppRev17}, 8'h01);
        chk({6'h00, parallelMode}, 8'h00);
        printerMode = 1'b0;
        for (int s = 0; s < 4; s++) begin
            put(8'h04, 8'(s << 2) | 8'(s) | 8'h10);
            chk({6'h00, parallelMode}, 8'(s));
            chk({6'h00, parallelShare}, (s == 3) ? 8'h02 : 8'(s));
        end
        for (int m = 1; m <= 2; m++) begin
            put(8'h04, 8'(m << 4));
            n0  = 0;
            n1  = 0;
            t0  = 0;
            gap = 0;
            for (int c = 0; c < 1600; c++) begin
                @(posedge mclk);
                #1;
                n0 += (midiTick[0] === 1'b1) ? 1 : 0;
                n1 += (midiTick[1] === 1'b1) ? 1 : 0;
                if (midiTick[m - 1] === 1'b1) begin
                    gap = c - t0;
                    t0  = c;
                end
            end
            chk(8'(n0), (m == 1) ? 8'h02 : 8'h00);
            chk(8'(n1), (m == 2) ? 8'h02 : 8'h00);
            chk(8'(gap), 8'(pfs_pkg::MIDI_DIV));
            chk(8'(gap >> 8), 8'(pfs_pkg::MIDI_DIV >> 8));
        end
        chk({7'h00, eppRev17}, 8'h00);
        $display("test extended setup done");
        host_u.set_cfg(1'b0);
        host_u.cfg_write(8'h03, 8'h00);
        rd_chk(8'h03, 1'b0, 8'h00);
        host_u.set_cfg(1'b1);
        rd_chk(8'h03, 1'b1, 8'h80);
        rd_chk(8'h05, 1'b0, 8'h00);
        host_u.step();
        lockEnable = 1'b0;
        host_u.step();
        lockEnable = 1'b1;
        put(8'h03, 8'h01);
        rd_chk(8'h03, 1'b0, 8'h00);
        chk({7'h00, gamePinOe}, 8'h00);
        host_u.step();
        rst = 1'b1;
        host_u.step();
        host_u.step();
        rst = 1'b0;
        rd_chk(8'h03, 1'b1, 8'h70);
        $display("test refusal and lock done");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
